// *** logic/lzs_regs.vh ***
`ifndef LZS_REGS_VH
`define LZS_REGS_VH
`define LZS_OFF_CFG      8'h00
`define LZS_OFF_AIMIN    8'h04
`define LZS_OFF_REFRNG   8'h08
`define LZS_OFF_FBRNG    8'h0c
`define LZS_OFF_FULL     8'h10
`define LZS_OFF_POWER    8'h14
`define LZS_OFF_FWARN    8'h18
`define LZS_OFF_IWARN    8'h1c
`define LZS_OFF_FBWARN   8'h20
`define LZS_OFF_STATUS   8'h24
`define LZS_RESP_OK      2'b00
`define LZS_RESP_ERR     2'b10
`define LZS_CLK_HZ       20000000
`define LZS_TICK_S       1
`define LZS_SEC_CYCLES   (`LZS_CLK_HZ * `LZS_TICK_S)
`define LZS_TMO_MIN      7'h01
`define LZS_TMO_MAX      7'h63
`define LZS_TMO_RST      7'h0a
`define LZS_VMIN_MAX     8'h64
`define LZS_IMIN_MAX     8'hc8
`define LZS_VMIN_RST     8'h00
`define LZS_IMIN_RST     8'h28
`define LZS_V_ACTIVE     9'h00a
`define LZS_I_ACTIVE     9'h014
`define LZS_RNG_RST      32'h03e8_0000
`define LZS_FULL_RST     32'h03e8_03e8
`define LZS_ACT_NONE     3'h0
`define LZS_ACT_HOLD     3'h1
`define LZS_ACT_STOP     3'h2
`define LZS_ACT_JOG      3'h3
`define LZS_ACT_MAX      3'h4
`define LZS_ACT_TRIP     3'h5
`define LZS_AO_LAST      4'hc
`define LZS_AO_BASE4     12'h190
`define LZS_AO_SPAN0     12'h7d0
`define LZS_AO_SPAN4     12'h640
`define LZS_TEMP_LO      16'h0014
`define LZS_TEMP_HI      16'h0064
`define LZS_FRAC_FULL    12'hfff
`endif

// *** logic/lzs_top.v ***
// Operation
// - flag loss below half of minimum scaling
// - act after low outlasts 1-99 s timeout
// - supervise only above 1 V / 2 mA
// - action codes 0-5 decode to fallbacks
// - live-zero action beats bus timeout action
// - output codes 1-12 pair quantity and span
// - reference, feedback, freq, current scale linearly
// - power full scale at rated motor power
// - temperature spans 20 to 100 degrees
// - relay codes 0, 1, 2
// - relay codes 3 and 4
// - relay codes 5 and 6
// - relay code 7 ready, supply, idle, line ok
// - code 8 alarm or warning, 10 alarm
// - code 9 current above limit
// - codes 11, 12 frequency thresholds
// - codes 13-16 current and feedback thresholds
// - codes 22-24 outside warning windows
// - codes 17-20, 25, 26 pass status
// - reverse: energised while counter-clockwise
// - control word bit 11 drives relay
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "lzs_regs.vh"
module lzs_top #(
  parameter integer SEC_CYCLES = `LZS_SEC_CYCLES
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // axi4-lite slave
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // analogue inputs, 0.1 V and 0.1 mA units
  input  wire [7:0]  AI_VOLT,
  input  wire        AI_VOLT_USED,
  input  wire [7:0]  AI_CURR,
  input  wire        AI_CURR_USED,
  // process quantities
  input  wire [15:0] REF_VALUE,
  input  wire [15:0] FB_VALUE,
  input  wire [15:0] FREQ_VALUE,
  input  wire [15:0] CURR_VALUE,
  input  wire [15:0] POWER_VALUE,
  input  wire [15:0] TEMP_VALUE,
  // fieldbus supervision
  input  wire        BUS_TIMEOUT,
  input  wire [2:0]  BUS_ACTION,
  // drive status
  input  wire        UNIT_READY,
  input  wire        ENABLED,
  input  wire        WARNING,
  input  wire        ALARM,
  input  wire        START_ACTIVE,
  input  wire        SPEED_ON_REF,
  input  wire        IN_REF_RANGE,
  input  wire        CTRL_POWER,
  input  wire        CONTROL_INPUT_ACTIVE,
  input  wire        LINE_VOLTAGE_OK,
  input  wire        BUS_RELAY,
  input  wire        REVERSE_CCW,
  input  wire        THERMAL_WARNING,
  input  wire        LOCAL_MODE,
  input  wire        BRAKE_DRIVE,
  input  wire [15:0] CONTROL_WORD,
  // fallback and outputs
  output reg         SIGNAL_LOSS,
  output reg         SIGNAL_LOSS_TIMEOUT,
  output reg  [2:0]  ACTION_CODE,
  output reg         HOLD_FREQ,
  output reg         FORCE_STOP,
  output reg         FORCE_JOG,
  output reg         FORCE_MAX,
  output reg         FORCE_TRIP,
  output reg  [11:0] AO_VALUE,
  output reg         RELAY
);

  localparam integer SEC_LAST_I = SEC_CYCLES - 1;
  localparam [24:0]  SEC_LAST   = SEC_LAST_I[24:0];

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wmerge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // full-scale and offset of the chosen span, in 0.01 mA
  function [11:0] ao_scale;
    input [11:0] frac;
    input        live;
    reg   [23:0] prod;
    begin
      prod = frac * (live ? `LZS_AO_SPAN4 : `LZS_AO_SPAN0);
      ao_scale = prod[23:12] + (live ? `LZS_AO_BASE4 : 12'h000);
    end
  endfunction

  function gt;
    input [15:0] a;
    input [15:0] b;
    begin
      gt = a > b;
    end
  endfunction

  // configuration
  reg  [6:0]  tmo_reg;
  reg  [2:0]  act_reg;
  reg  [3:0]  ao_src_reg;
  reg  [4:0]  rly_src_reg;
  reg  [7:0]  vmin_reg;
  reg  [7:0]  imin_reg;
  reg  [31:0] refrng_reg;
  reg  [31:0] fbrng_reg;
  reg  [31:0] full_reg;
  reg  [31:0] power_reg;
  reg  [31:0] fwarn_reg;
  reg  [31:0] iwarn_reg;
  reg  [31:0] fbwarn_reg;

  // bus slave state
  reg         aw_held_reg;
  reg  [7:0]  awaddr_reg;
  reg         w_held_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;

  assign S_AXI_AWREADY = ~aw_held_reg;
  assign S_AXI_WREADY  = ~w_held_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  wire do_wr = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire [31:0] cfg_rd = {3'h0, rly_src_reg, 4'h0, ao_src_reg,
                        5'h00, act_reg, 1'b0, tmo_reg};
  wire [31:0] cfg_m  = wmerge(cfg_rd, wdata_reg, wstrb_reg);
  wire [31:0] ai_rd  = {8'h00, imin_reg, 8'h00, vmin_reg};
  wire [31:0] ai_m   = wmerge(ai_rd, wdata_reg, wstrb_reg);

  // live-zero supervision
  reg  [24:0] presc_reg;
  reg  [6:0]  sec_reg;
  reg         timed_reg;
  wire        v_on  = {1'b0, vmin_reg} > `LZS_V_ACTIVE;
  wire        i_on  = {1'b0, imin_reg} > `LZS_I_ACTIVE;
  wire        v_low = AI_VOLT_USED & v_on & ({AI_VOLT, 1'b0} < {1'b0, vmin_reg});
  wire        i_low = AI_CURR_USED & i_on & ({AI_CURR, 1'b0} < {1'b0, imin_reg});
  wire        low   = v_low | i_low;

  wire [31:0] status_rd = {4'h0, AO_VALUE, 1'b0, sec_reg,
                           2'h0, RELAY, ACTION_CODE, timed_reg, low};

  // write channel
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `LZS_RESP_OK;
      tmo_reg     <= `LZS_TMO_RST;
      act_reg     <= `LZS_ACT_NONE;
      ao_src_reg  <= 4'h0;
      rly_src_reg <= 5'h00;
      vmin_reg    <= `LZS_VMIN_RST;
      imin_reg    <= `LZS_IMIN_RST;
      refrng_reg  <= `LZS_RNG_RST;
      fbrng_reg   <= `LZS_RNG_RST;
      full_reg    <= `LZS_FULL_RST;
      power_reg   <= `LZS_FULL_RST;
      fwarn_reg   <= `LZS_RNG_RST;
      iwarn_reg   <= `LZS_RNG_RST;
      fbwarn_reg  <= `LZS_RNG_RST;
    end else begin
      if (S_AXI_AWVALID & ~aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & ~w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (bvalid_reg & S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (do_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= `LZS_RESP_OK;
        case (awaddr_reg)
          `LZS_OFF_CFG: begin
            // out-of-range times clamp rather than fault
            if (cfg_m[6:0] < `LZS_TMO_MIN) tmo_reg <= `LZS_TMO_MIN;
            else if (cfg_m[6:0] > `LZS_TMO_MAX) tmo_reg <= `LZS_TMO_MAX;
            else tmo_reg <= cfg_m[6:0];
            act_reg     <= (cfg_m[10:8] > `LZS_ACT_TRIP) ? `LZS_ACT_NONE : cfg_m[10:8];
            ao_src_reg  <= cfg_m[19:16];
            rly_src_reg <= cfg_m[28:24];
          end
          `LZS_OFF_AIMIN: begin
            vmin_reg <= (ai_m[7:0] > `LZS_VMIN_MAX) ? `LZS_VMIN_MAX : ai_m[7:0];
            imin_reg <= (ai_m[23:16] > `LZS_IMIN_MAX) ? `LZS_IMIN_MAX : ai_m[23:16];
          end
          `LZS_OFF_REFRNG: refrng_reg <= wmerge(refrng_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_FBRNG:  fbrng_reg  <= wmerge(fbrng_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_FULL:   full_reg   <= wmerge(full_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_POWER:  power_reg  <= wmerge(power_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_FWARN:  fwarn_reg  <= wmerge(fwarn_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_IWARN:  iwarn_reg  <= wmerge(iwarn_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_FBWARN: fbwarn_reg <= wmerge(fbwarn_reg, wdata_reg, wstrb_reg);
          `LZS_OFF_STATUS: bresp_reg  <= `LZS_RESP_OK;
          default:         bresp_reg  <= `LZS_RESP_ERR;
        endcase
      end
    end
  end

  // read channel
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `LZS_RESP_OK;
    end else if (rvalid_reg) begin
      if (S_AXI_RREADY) rvalid_reg <= 1'b0;
    end else if (S_AXI_ARVALID) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `LZS_RESP_OK;
      case (S_AXI_ARADDR)
        `LZS_OFF_CFG:    rdata_reg <= cfg_rd;
        `LZS_OFF_AIMIN:  rdata_reg <= ai_rd;
        `LZS_OFF_REFRNG: rdata_reg <= refrng_reg;
        `LZS_OFF_FBRNG:  rdata_reg <= fbrng_reg;
        `LZS_OFF_FULL:   rdata_reg <= full_reg;
        `LZS_OFF_POWER:  rdata_reg <= power_reg;
        `LZS_OFF_FWARN:  rdata_reg <= fwarn_reg;
        `LZS_OFF_IWARN:  rdata_reg <= iwarn_reg;
        `LZS_OFF_FBWARN: rdata_reg <= fbwarn_reg;
        `LZS_OFF_STATUS: rdata_reg <= status_rd;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `LZS_RESP_ERR;
        end
      endcase
    end
  end

  // timeout timer and fallback selection
  wire [2:0] act_next = timed_reg ? act_reg :
                        (BUS_TIMEOUT ? BUS_ACTION : `LZS_ACT_NONE);
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      presc_reg           <= 25'h0000000;
      sec_reg             <= 7'h00;
      timed_reg           <= 1'b0;
      SIGNAL_LOSS         <= 1'b0;
      SIGNAL_LOSS_TIMEOUT <= 1'b0;
      ACTION_CODE         <= `LZS_ACT_NONE;
      HOLD_FREQ           <= 1'b0;
      FORCE_STOP          <= 1'b0;
      FORCE_JOG           <= 1'b0;
      FORCE_MAX           <= 1'b0;
      FORCE_TRIP          <= 1'b0;
    end else begin
      if (!low) begin
        presc_reg <= 25'h0000000;
        sec_reg   <= 7'h00;
        timed_reg <= 1'b0;
      end else if (!timed_reg) begin
        if (sec_reg >= tmo_reg) begin
          timed_reg <= 1'b1;
        end else if (presc_reg == SEC_LAST) begin
          presc_reg <= 25'h0000000;
          sec_reg   <= sec_reg + 7'h01;
        end else begin
          presc_reg <= presc_reg + 25'h0000001;
        end
      end
      SIGNAL_LOSS         <= low;
      SIGNAL_LOSS_TIMEOUT <= timed_reg;
      ACTION_CODE         <= act_next;
      HOLD_FREQ           <= act_next == `LZS_ACT_HOLD;
      FORCE_STOP          <= act_next == `LZS_ACT_STOP ||
                             act_next == `LZS_ACT_TRIP;
      FORCE_JOG           <= act_next == `LZS_ACT_JOG;
      FORCE_MAX           <= act_next == `LZS_ACT_MAX;
      FORCE_TRIP          <= act_next == `LZS_ACT_TRIP;
    end
  end

  // analogue output: range select then serial divide
  reg [15:0] q_val;
  reg [15:0] q_lo;
  reg [15:0] q_hi;
  wire [3:0] q_idx = ao_src_reg - 4'h1;
  always @* begin
    q_val = 16'h0000;
    q_lo  = 16'h0000;
    q_hi  = 16'h0000;
    case (q_idx[3:1])
      3'h0: begin
        q_val = REF_VALUE;
        q_lo  = refrng_reg[15:0];
        q_hi  = refrng_reg[31:16];
      end
      3'h1: begin
        q_val = FB_VALUE;
        q_lo  = fbrng_reg[15:0];
        q_hi  = fbrng_reg[31:16];
      end
      3'h2: begin
        q_val = FREQ_VALUE;
        q_hi  = full_reg[15:0];
      end
      3'h3: begin
        q_val = CURR_VALUE;
        q_hi  = full_reg[31:16];
      end
      3'h4: begin
        q_val = POWER_VALUE;
        q_hi  = power_reg[15:0];
      end
      3'h5: begin
        q_val = TEMP_VALUE;
        q_lo  = `LZS_TEMP_LO;
        q_hi  = `LZS_TEMP_HI;
      end
      default: q_val = 16'h0000;
    endcase
  end

  reg        div_busy_reg;
  reg [3:0]  div_cnt_reg;
  reg [15:0] rem_reg;
  reg [15:0] den_reg;
  reg [11:0] quo_reg;
  reg        live_reg;
  wire [16:0] rem2   = {rem_reg, 1'b0};
  wire        ge_den = rem2 >= {1'b0, den_reg};
  wire [16:0] rem_sb = rem2 - {1'b0, den_reg};
  wire        ao_off = (ao_src_reg == 4'h0) || (ao_src_reg > `LZS_AO_LAST);
  wire        span4  = q_idx[0];

  // update rate is one conversion per 13 clocks; plenty for a process value
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_busy_reg <= 1'b0;
      div_cnt_reg  <= 4'h0;
      rem_reg      <= 16'h0000;
      den_reg      <= 16'h0000;
      quo_reg      <= 12'h000;
      live_reg     <= 1'b0;
      AO_VALUE     <= 12'h000;
    end else if (div_busy_reg) begin
      rem_reg     <= ge_den ? rem_sb[15:0] : rem2[15:0];
      quo_reg     <= {quo_reg[10:0], ge_den};
      div_cnt_reg <= div_cnt_reg - 4'h1;
      if (div_cnt_reg == 4'h0) begin
        div_busy_reg <= 1'b0;
        if (!ao_off) AO_VALUE <= ao_scale({quo_reg[10:0], ge_den}, live_reg);
        else AO_VALUE <= 12'h000;
      end
    end else if (ao_off) begin
      AO_VALUE <= 12'h000;
    end else if (q_hi <= q_lo || q_val <= q_lo) begin
      AO_VALUE <= ao_scale(12'h000, span4);
    end else if (q_val >= q_hi) begin
      // both spans top out at 20 mA; the divider path alone stops one step short
      AO_VALUE <= `LZS_AO_SPAN0;
    end else begin
      div_busy_reg <= 1'b1;
      div_cnt_reg  <= 4'hb;
      rem_reg      <= q_val - q_lo;
      den_reg      <= q_hi - q_lo;
      quo_reg      <= 12'h000;
      live_reg     <= span4;
    end
  end

  // relay function
  reg rly_next;
  always @* begin
    case (rly_src_reg)
      5'd1:  rly_next = UNIT_READY;
      5'd2:  rly_next = ENABLED & ~WARNING;
      5'd3:  rly_next = START_ACTIVE;
      5'd4:  rly_next = SPEED_ON_REF & ~WARNING;
      5'd5:  rly_next = START_ACTIVE & ~WARNING;
      5'd6:  rly_next = IN_REF_RANGE & ~WARNING;
      5'd7:  rly_next = UNIT_READY & CTRL_POWER &
                        ~CONTROL_INPUT_ACTIVE & LINE_VOLTAGE_OK;
      5'd8:  rly_next = ALARM | WARNING;
      5'd9:  rly_next = gt(CURR_VALUE, power_reg[31:16]);
      5'd10: rly_next = ALARM;
      5'd11: rly_next = gt(FREQ_VALUE, fwarn_reg[15:0]);
      5'd12: rly_next = gt(fwarn_reg[31:16], FREQ_VALUE);
      5'd13: rly_next = gt(CURR_VALUE, iwarn_reg[15:0]);
      5'd14: rly_next = gt(iwarn_reg[31:16], CURR_VALUE);
      5'd15: rly_next = gt(FB_VALUE, fbwarn_reg[15:0]);
      5'd16: rly_next = gt(fbwarn_reg[31:16], FB_VALUE);
      5'd17: rly_next = BUS_RELAY;
      5'd18: rly_next = REVERSE_CCW;
      5'd19: rly_next = THERMAL_WARNING;
      5'd20: rly_next = LOCAL_MODE;
      5'd22: rly_next = gt(fwarn_reg[15:0], FREQ_VALUE) |
                        gt(FREQ_VALUE, fwarn_reg[31:16]);
      5'd23: rly_next = gt(iwarn_reg[15:0], CURR_VALUE) |
                        gt(CURR_VALUE, iwarn_reg[31:16]);
      5'd24: rly_next = gt(fbwarn_reg[15:0], FB_VALUE) |
                        gt(FB_VALUE, fbwarn_reg[31:16]);
      5'd25: rly_next = BRAKE_DRIVE;
      5'd26: rly_next = CONTROL_WORD[11];
      default: rly_next = 1'b0;
    endcase
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) RELAY <= 1'b0;
    else RELAY <= rly_next;
  end

endmodule // lzs_top

// *** dv/lzs_top_chk.sv ***
`timescale 1ns/1ns
module lzs_top_chk #(
  parameter integer SEC_CYCLES = 20
) (
  // clock and reset
  input logic        CLK,
  input logic        RESET,
  // bus answers
  input logic        S_AXI_BVALID,
  input logic        S_AXI_BREADY,
  input logic [1:0]  S_AXI_BRESP,
  input logic        S_AXI_RVALID,
  input logic        S_AXI_RREADY,
  input logic [31:0] S_AXI_RDATA,
  // supervision
  input logic        AI_VOLT_USED,
  input logic        AI_CURR_USED,
  input logic        BUS_TIMEOUT,
  input logic [2:0]  BUS_ACTION,
  input logic        SIGNAL_LOSS,
  input logic        SIGNAL_LOSS_TIMEOUT,
  input logic [2:0]  ACTION_CODE,
  input logic        HOLD_FREQ,
  input logic        FORCE_STOP,
  input logic        FORCE_TRIP,
  input logic [11:0] AO_VALUE
);
  integer low_reg;
  // length of the current unbroken low period
  always @(posedge CLK or posedge RESET)
    if (RESET) low_reg <= 0;
    else low_reg <= SIGNAL_LOSS ? low_reg + 1 : 0;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer not held");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer not held");
  tmo_early_a: assert property ($rose(SIGNAL_LOSS_TIMEOUT) |-> low_reg >= SEC_CYCLES)
    else $error("timeout before one second of loss");
  tmo_late_a: assert property (SIGNAL_LOSS && low_reg > 99 * SEC_CYCLES + 8 |->
    SIGNAL_LOSS_TIMEOUT) else $error("timeout missing after longest setting");
  tmo_clear_a: assert property ($fell(SIGNAL_LOSS) |-> ##[0:1] !SIGNAL_LOSS_TIMEOUT)
    else $error("timeout kept after recovery");
  unused_in_a: assert property ((!AI_VOLT_USED && !AI_CURR_USED)[*2] |-> !SIGNAL_LOSS)
    else $error("loss flagged on unused inputs");
  trip_decode_a: assert property (ACTION_CODE == 3'h5 |->
    FORCE_STOP && FORCE_TRIP && !HOLD_FREQ) else $error("stop and trip decode wrong");
  idle_action_a: assert property ((!BUS_TIMEOUT && !SIGNAL_LOSS_TIMEOUT)[*2] |->
    ACTION_CODE == 3'h0) else $error("action without any timeout");
  bus_action_a: assert property ((BUS_TIMEOUT && !SIGNAL_LOSS_TIMEOUT)[*3] |->
    ACTION_CODE == $past(BUS_ACTION)) else $error("bus timeout action not applied");
  ao_span_a: assert property (AO_VALUE <= 12'h7d0)
    else $error("output above full scale");
endmodule // lzs_top_chk
bind lzs_top lzs_top_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.CLK(CLK), .RESET(RESET),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .AI_VOLT_USED(AI_VOLT_USED), .AI_CURR_USED(AI_CURR_USED), .BUS_TIMEOUT(BUS_TIMEOUT),
  .BUS_ACTION(BUS_ACTION), .SIGNAL_LOSS(SIGNAL_LOSS),
  .SIGNAL_LOSS_TIMEOUT(SIGNAL_LOSS_TIMEOUT), .ACTION_CODE(ACTION_CODE),
  .HOLD_FREQ(HOLD_FREQ), .FORCE_STOP(FORCE_STOP), .FORCE_TRIP(FORCE_TRIP),
  .AO_VALUE(AO_VALUE));

// *** dv/lzs_field.sv ***
`timescale 1ns/1ns
module lzs_field (
  // clock
  input logic        clk,
  // commanded sensor levels
  input logic [7:0]  volt_lvl,
  input logic [7:0]  curr_lvl,
  // terminal values
  output logic [7:0] ai_volt,
  output logic [7:0] ai_curr
);
  initial begin
    ai_volt = 8'h64;
    ai_curr = 8'hc8;
  end
  // sensors settle one sample after a change, never instantly
  always @(posedge clk) begin
    ai_volt <= volt_lvl;
    ai_curr <= curr_lvl;
  end
endmodule // lzs_field

// *** dv/test_lzs_top.sv ***
`timescale 1ns/1ns
`include "lzs_regs.vh"
module test_lzs_top;
  logic CLK = 0, RESET = 1, AI_VOLT_USED = 0, AI_CURR_USED = 0, BUS_TIMEOUT = 0;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, RELAY;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, AI_VOLT, AI_CURR, v_lvl = 100, c_lvl = 200;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [2:0] BUS_ACTION = 0, ACTION_CODE;
  logic [15:0] REF_VALUE = 0, FB_VALUE = 0, FREQ_VALUE = 0, CURR_VALUE = 0;
  logic [15:0] POWER_VALUE = 0, TEMP_VALUE = 0, CONTROL_WORD = 0, st = 0;
  logic UNIT_READY, ENABLED, WARNING, ALARM, START_ACTIVE, SPEED_ON_REF, IN_REF_RANGE;
  logic CTRL_POWER, CONTROL_INPUT_ACTIVE, LINE_VOLTAGE_OK, BUS_RELAY, REVERSE_CCW;
  logic THERMAL_WARNING, LOCAL_MODE, BRAKE_DRIVE, SIGNAL_LOSS, SIGNAL_LOSS_TIMEOUT;
  logic HOLD_FREQ, FORCE_STOP, FORCE_JOG, FORCE_MAX, FORCE_TRIP;
  logic [11:0] AO_VALUE;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  assign {UNIT_READY, ENABLED, WARNING, ALARM, START_ACTIVE, SPEED_ON_REF, IN_REF_RANGE,
    CTRL_POWER, CONTROL_INPUT_ACTIVE, LINE_VOLTAGE_OK, BUS_RELAY, REVERSE_CCW,
    THERMAL_WARNING, LOCAL_MODE, BRAKE_DRIVE} = st[14:0];
  // one second is 20 cycles so the 99 s case stays short
  lzs_top #(.SEC_CYCLES(20)) DUT (.*);
  lzs_field u_field (.clk(CLK), .volt_lvl(v_lvl), .curr_lvl(c_lvl), .ai_volt(AI_VOLT),
    .ai_curr(AI_CURR));
  initial forever #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task test_done;
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] e);
    check_count++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, e);
    end
  endtask
  // handshakes are judged at the falling edge, where the levels are settled
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    logic aw, w;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    forever begin
      @(negedge CLK);
      aw = S_AXI_AWVALID && S_AXI_AWREADY;
      w = S_AXI_WVALID && S_AXI_WREADY;
      if (S_AXI_BVALID) break;
      @(posedge CLK);
      if (aw) S_AXI_AWVALID <= 0;
      if (w) S_AXI_WVALID <= 0;
    end
    chk(S_AXI_BRESP, e);
    @(posedge CLK);
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    logic ar;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    forever begin
      @(negedge CLK);
      ar = S_AXI_ARVALID && S_AXI_ARREADY;
      if (S_AXI_RVALID) break;
      @(posedge CLK);
      if (ar) S_AXI_ARVALID <= 0;
    end
    chk(S_AXI_RDATA, e);
    chk(S_AXI_RRESP, er);
    @(posedge CLK);
  endtask
  function [31:0] cfg(input [6:0] t, input [2:0] act, input [3:0] src, input [4:0] rel);
    return {3'h0, rel, 4'h0, src, 5'h0, act, 1'h0, t};
  endfunction
  function [4:0] flags(input [2:0] a);
    return {a == 1, a == 2 || a == 5, a == 3, a == 4, a == 5};
  endfunction
  // warning windows 100..200 and current limit 150 as programmed below
  function logic exp_relay(input [4:0] c);
    logic [31:0] v;
    logic fo, io, bo;
    fo = FREQ_VALUE < 100 || FREQ_VALUE > 200;
    io = CURR_VALUE < 100 || CURR_VALUE > 200;
    bo = FB_VALUE < 100 || FB_VALUE > 200;
    v = {5'h0, CONTROL_WORD[11], BRAKE_DRIVE, bo, io, fo, 1'b0, LOCAL_MODE, THERMAL_WARNING,
      REVERSE_CCW, BUS_RELAY, FB_VALUE < 200, FB_VALUE > 100, CURR_VALUE < 200,
      CURR_VALUE > 100, FREQ_VALUE < 200, FREQ_VALUE > 100, ALARM, CURR_VALUE > 150,
      ALARM | WARNING, UNIT_READY & CTRL_POWER & !CONTROL_INPUT_ACTIVE & LINE_VOLTAGE_OK,
      IN_REF_RANGE & !WARNING, START_ACTIVE & !WARNING, SPEED_ON_REF & !WARNING,
      START_ACTIVE, ENABLED & !WARNING, UNIT_READY, 1'b0};
    return v[c];
  endfunction
  task look(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task lz(input [7:0] vmin, imin, input vu, cu, input [7:0] av, ac, input e);
    wr(`LZS_OFF_AIMIN, {8'h0, imin, 8'h0, vmin}, `LZS_RESP_OK);
    AI_VOLT_USED <= vu;
    AI_CURR_USED <= cu;
    v_lvl <= av;
    c_lvl <= ac;
    look(6);
    chk(SIGNAL_LOSS, e);
    @(posedge CLK);
  endtask
  task ao(input [3:0] src, input [15:0] q, t, input [11:0] e);
    wr(`LZS_OFF_CFG, cfg(10, 0, src, 0), `LZS_RESP_OK);
    {REF_VALUE, FB_VALUE, FREQ_VALUE, CURR_VALUE, POWER_VALUE} <= {5{q}};
    TEMP_VALUE <= t;
    // an in-flight divide of the old setting finishes first, then a fresh one runs
    look(30);
    chk(AO_VALUE, e);
    @(posedge CLK);
  endtask
  initial begin
    void'($urandom(32'h2bc5));
    repeat (4) @(posedge CLK);
    RESET <= 0;
    @(posedge CLK);
    rd(`LZS_OFF_CFG, 32'h0000_000a, `LZS_RESP_OK);
    rd(`LZS_OFF_AIMIN, 32'h0028_0000, `LZS_RESP_OK);
    rd(`LZS_OFF_REFRNG, `LZS_RNG_RST, `LZS_RESP_OK);
    rd(8'h40, 32'h0, `LZS_RESP_ERR);
    wr(8'h44, 32'h1, `LZS_RESP_ERR);
    wr(`LZS_OFF_CFG, cfg(7'h7f, 7, 0, 0), `LZS_RESP_OK);
    rd(`LZS_OFF_CFG, 32'h0000_0063, `LZS_RESP_OK);
    lz(10, 20, 1, 1, 0, 0, 0);
    lz(20, 40, 1, 0, 10, 0, 0);
    lz(20, 40, 1, 0, 9, 0, 1);
    lz(20, 40, 0, 1, 200, 19, 1);
    lz(20, 40, 0, 1, 200, 20, 0);
    lz(20, 40, 0, 0, 0, 0, 0);
    AI_VOLT_USED <= 1;
    BUS_TIMEOUT <= 1;
    v_lvl <= 200;
    for (int a = 0; a < 6; a++) begin
      BUS_ACTION <= 3'($urandom % 6);
      wr(`LZS_OFF_CFG, cfg(1, 3'(a), 0, 0), `LZS_RESP_OK);
      v_lvl <= 9;
      look(14);
      chk(SIGNAL_LOSS_TIMEOUT, 0);
      look(16);
      chk(ACTION_CODE, a);
      chk({HOLD_FREQ, FORCE_STOP, FORCE_JOG, FORCE_MAX, FORCE_TRIP}, flags(3'(a)));
      @(posedge CLK);
      v_lvl <= 200;
      look(5);
      chk(SIGNAL_LOSS_TIMEOUT, 0);
      chk(ACTION_CODE, BUS_ACTION);
      @(posedge CLK);
    end
    v_lvl <= 9;
    repeat (15) @(posedge CLK);
    v_lvl <= 200;
    repeat (3) @(posedge CLK);
    v_lvl <= 9;
    look(15);
    chk(SIGNAL_LOSS_TIMEOUT, 0);
    @(posedge CLK);
    v_lvl <= 200;
    wr(`LZS_OFF_CFG, cfg(99, 2, 0, 0), `LZS_RESP_OK);
    v_lvl <= 9;
    look(1970);
    chk(SIGNAL_LOSS_TIMEOUT, 0);
    look(45);
    chk({SIGNAL_LOSS_TIMEOUT, FORCE_STOP}, 2'b11);
    @(posedge CLK);
    v_lvl <= 200;
    ao(0, 1000, 100, 0);
    ao(1, 1000, 20, 12'h7d0);
    ao(2, 0, 20, 12'h190);
    ao(1, 500, 20, 12'h3e8);
    ao(4, 500, 20, 12'h4b0);
    ao(11, 0, 60, 12'h3e8);
    ao(5, 1000, 20, 12'h7d0);
    ao(9, 1000, 20, 12'h7d0);
    ao(11, 0, 100, 12'h7d0);
    ao(12, 0, 10, 12'h190);
    ao(13, 1000, 100, 0);
    wr(`LZS_OFF_FWARN, 32'h00c8_0064, `LZS_RESP_OK);
    wr(`LZS_OFF_IWARN, 32'h00c8_0064, `LZS_RESP_OK);
    wr(`LZS_OFF_FBWARN, 32'h00c8_0064, `LZS_RESP_OK);
    wr(`LZS_OFF_POWER, 32'h0096_03e8, `LZS_RESP_OK);
    for (int c = 0; c < 32; c++) begin
      wr(`LZS_OFF_CFG, cfg(10, 0, 0, 5'(c)), `LZS_RESP_OK);
      for (int k = 0; k < 4; k++) begin
        // first vector sits exactly on the thresholds
        st <= 16'($urandom);
        CONTROL_WORD <= 16'($urandom);
        FREQ_VALUE <= k ? 16'($urandom % 300) : 16'd100;
        CURR_VALUE <= k ? 16'($urandom % 300) : 16'd150;
        FB_VALUE <= k ? 16'($urandom % 300) : 16'd200;
        look(3);
        if (c < 13) chk(RELAY, exp_relay(5'(c)));
        else chk(RELAY, exp_relay(5'(c)));
        @(posedge CLK);
      end
    end
    test_done();
  end
endmodule // test_lzs_top
